// ==== core/brg_core.sv ====
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - one sample per clock, level decided by majority of the last three
// - async narrow low speed: rate = clock / (64 * (n + 1))
// - async wide low speed: rate = clock / (16 * (n + 1))
// - sync master: rate = clock / (4 * (n + 1)), any width
// - n is high divisor byte above low divisor byte
// - default narrow divisor ignores high byte; wide select uses both
// - write to either divisor byte resets the rate timer at once
// - formulas apply in async and sync master; sync slave uses external clock pin
module sbrg_core
  import sbrg_pkg::*;
(
  // clock, reset, enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // line pins
  input  wire logic        i_rx_line,
  input  wire logic        i_ext_clk,
  // to shifters
  output logic             o_bit_tick,
  output logic             o_sample_tick,
  output logic             o_rx_level,
  output logic             o_port_en
);

  // ************************************************
  // register bus
  // ************************************************
  logic [7:0]  tx_ctrl_ff, rx_ctrl_ff, rate_ctrl_ff, div_hi_ff, div_lo_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic        div_write;
  sbrg_cfg_t   cfg;

  wire addr_take = i_hsel & i_hready & i_htrans[1];

  function automatic logic [7:0] read_mux(input logic [7:0] a);
    unique case (a)
      ADDR_TX_CTRL:   read_mux = tx_ctrl_ff;
      ADDR_RX_CTRL:   read_mux = rx_ctrl_ff;
      ADDR_RATE_CTRL: read_mux = rate_ctrl_ff;
      ADDR_DIV_HIGH:  read_mux = div_hi_ff;
      ADDR_DIV_LOW:   read_mux = div_lo_ff;
      ADDR_STATUS:    read_mux = {7'h00, o_rx_level};
      default:        read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // address phase capture; zero wait states
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h0000_0000;
    end else if (i_clk_en) begin
      wr_pend_ff <= addr_take & i_hwrite;
      wr_addr_ff <= i_haddr[7:0];
      if (addr_take & ~i_hwrite) begin
        hrdata_ff <= {24'h00_0000, read_mux(i_haddr[7:0])};
      end
    end
  end

  assign o_hrdata    = hrdata_ff;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // data phase write; unmapped addresses are ignored
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_ctrl_ff   <= RST_TX_CTRL;
      rx_ctrl_ff   <= RST_RX_CTRL;
      rate_ctrl_ff <= RST_RATE_CTRL;
      div_hi_ff    <= RST_DIV;
      div_lo_ff    <= RST_DIV;
    end else if (i_clk_en && wr_pend_ff) begin
      unique case (wr_addr_ff)
        ADDR_TX_CTRL:   tx_ctrl_ff   <= i_hwdata[7:0];
        ADDR_RX_CTRL:   rx_ctrl_ff   <= i_hwdata[7:0];
        ADDR_RATE_CTRL: rate_ctrl_ff <= i_hwdata[7:0] & 8'hFB;
        ADDR_DIV_HIGH:  div_hi_ff    <= i_hwdata[7:0];
        ADDR_DIV_LOW:   div_lo_ff    <= i_hwdata[7:0];
        default: ;
      endcase
    end
  end

  assign div_write = wr_pend_ff &
                     (wr_addr_ff == ADDR_DIV_HIGH ||
                      wr_addr_ff == ADDR_DIV_LOW);

  assign cfg.clk_src  = tx_ctrl_ff[POS_CLK_SRC];
  assign cfg.sync     = tx_ctrl_ff[POS_SYNC];
  assign cfg.high_spd = tx_ctrl_ff[POS_HIGH_SPD];
  assign cfg.port_en  = rx_ctrl_ff[POS_PORT_EN];
  assign cfg.wide_div = rate_ctrl_ff[POS_WIDE_DIV];
  assign o_port_en    = cfg.port_en;

  // ************************************************
  // rate timer
  // ************************************************
  logic [15:0] divisor;
  logic [6:0]  prescale;
  logic [15:0] timer_ff;
  logic [5:0]  pre_ff;
  logic        tick_ff;

  // narrow mode drops the high byte
  assign divisor = cfg.wide_div ? {div_hi_ff, div_lo_ff}
                                : {8'h00, div_lo_ff};

  // prescale per link mode, width and speed
  always_comb begin
    if (cfg.sync)                          prescale = PRE_4;
    else if (!cfg.wide_div && !cfg.high_spd) prescale = PRE_64;
    else if (cfg.wide_div && !cfg.high_spd)  prescale = PRE_16;
    else if (!cfg.wide_div)                  prescale = PRE_16;
    else                                     prescale = PRE_4;
  end

  // the timer counts 0..n once per prescale slot; a divisor write
  // restarts it so the new rate need not wait out the old period
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_ff   <= 6'h00;
      timer_ff <= 16'h0000;
      tick_ff  <= 1'b0;
    end else if (i_clk_en) begin
      tick_ff <= 1'b0;
      if (!cfg.port_en || div_write) begin
        pre_ff   <= 6'h00;
        timer_ff <= 16'h0000;
      end else if (pre_ff == 6'(prescale - 7'h01)) begin
        pre_ff <= 6'h00;
        if (timer_ff >= divisor) begin
          timer_ff <= 16'h0000;
          tick_ff  <= 1'b1;
        end else begin
          timer_ff <= timer_ff + 16'h0001;
        end
      end else begin
        pre_ff <= pre_ff + 6'h01;
      end
    end
  end

  // ************************************************
  // pin sync, clock source, majority vote
  // ************************************************
  logic [1:0] rx_sync_ff, ck_sync_ff;
  logic       ck_last_ff;
  logic [2:0] vote_ff;
  logic       level_ff;
  logic       slave_edge;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_sync_ff <= 2'b11;
      ck_sync_ff <= 2'b00;
      ck_last_ff <= 1'b0;
    end else if (i_clk_en) begin
      rx_sync_ff <= {rx_sync_ff[0], i_rx_line};
      ck_sync_ff <= {ck_sync_ff[0], i_ext_clk};
      ck_last_ff <= ck_sync_ff[1];
    end
  end

  assign slave_edge = ck_sync_ff[1] & ~ck_last_ff;

  // slave sync takes its bit clock from the external pin
  assign o_bit_tick = (cfg.sync && !cfg.clk_src) ? slave_edge
                                                 : tick_ff;
  assign o_sample_tick = o_bit_tick;

  // three samples at successive clocks; output is majority
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vote_ff  <= 3'b111;
      level_ff <= 1'b1;
    end else if (i_clk_en) begin
      if (!cfg.port_en) begin
        vote_ff  <= 3'b111;
        level_ff <= 1'b1;
      end else begin
        vote_ff  <= {vote_ff[1:0], rx_sync_ff[1]};
        level_ff <= (vote_ff[0] & vote_ff[1]) | (vote_ff[0] & vote_ff[2])
                  | (vote_ff[1] & vote_ff[2]);
      end
    end
  end

  assign o_rx_level = level_ff;

  // ************************************************
  // checks
  // ************************************************
  chk_div_restart: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) (i_clk_en && div_write)
      |=> (timer_ff == 16'h0000 && pre_ff == 6'h00))
    else $error("divisor write did not restart timer");
  chk_narrow_pre: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) (!cfg.sync && !cfg.wide_div && !cfg.high_spd)
      |-> prescale == PRE_64)
    else $error("narrow low speed prescale wrong");
  chk_wide_pre: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) (!cfg.sync && cfg.wide_div && !cfg.high_spd)
      |-> prescale == PRE_16)
    else $error("wide low speed prescale wrong");
  chk_sync_pre: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) cfg.sync |-> prescale == PRE_4)
    else $error("sync prescale wrong");
  chk_hs_pre: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) (!cfg.sync && cfg.high_spd)
      |-> prescale == (cfg.wide_div ? PRE_4 : PRE_16))
    else $error("high speed prescale wrong");
  chk_narrow_div: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) !cfg.wide_div |-> divisor[15:8] == 8'h00)
    else $error("high byte leaked in narrow mode");
  chk_wide_div: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) cfg.wide_div
      |-> divisor == {div_hi_ff, div_lo_ff})
    else $error("wide divisor not concatenated");
  chk_vote_out: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) (i_clk_en && cfg.port_en && vote_ff == 3'b000)
      |=> !level_ff)
    else $error("majority vote wrong");
  chk_slave_clk: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst) (cfg.sync && !cfg.clk_src)
      |-> o_bit_tick == slave_edge)
    else $error("slave clock not from pin");
  cov_tick: cover property (@(posedge i_ref_clk) tick_ff);
  cov_wide: cover property (@(posedge i_ref_clk) cfg.wide_div && tick_ff);
  cov_restart: cover property (@(posedge i_ref_clk) div_write);

endmodule : sbrg_core

// ==== pkg/brg_pkg.sv ====
package sbrg_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ADDR_TX_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RX_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_RATE_CTRL = 8'h08;
  localparam logic [7:0] ADDR_DIV_HIGH  = 8'h0C;
  localparam logic [7:0] ADDR_DIV_LOW   = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  // field positions
  localparam int POS_CLK_SRC   = 7;
  localparam int POS_SYNC      = 4;
  localparam int POS_HIGH_SPD  = 2;
  localparam int POS_PORT_EN   = 7;
  localparam int POS_WIDE_DIV  = 3;
  // reset values
  localparam logic [7:0] RST_TX_CTRL   = 8'h02;
  localparam logic [7:0] RST_RX_CTRL   = 8'h00;
  localparam logic [7:0] RST_RATE_CTRL = 8'h00;
  localparam logic [7:0] RST_DIV       = 8'h00;
  // prescale factors
  localparam logic [6:0] PRE_64 = 7'h40;
  localparam logic [6:0] PRE_16 = 7'h10;
  localparam logic [6:0] PRE_4  = 7'h04;
  // timing: clock rate
  localparam int REF_CLK_HZ = 40000000;
  localparam int REF_CLK_NS = 1000000000 / REF_CLK_HZ;
  // samples per majority vote
  localparam int VOTE_SAMPLES = 3;

  typedef struct packed {
    logic        clk_src;
    logic        sync;
    logic        high_spd;
    logic        port_en;
    logic        wide_div;
  } sbrg_cfg_t;
endpackage : sbrg_pkg

// ==== verif/brg_line_model.sv ====
`timescale 1ns/1ps
// ***********************************************
// far-side transceiver: serial line, slave clock
// ***********************************************
module sbrg_line_model (
  input  wire logic i_ref_clk,
  input  wire logic i_level,
  input  wire logic i_flip,
  input  wire logic i_ext_run,
  output logic      o_rx_line,
  output logic      o_ext_clk = 1'b0
);
  logic [2:0] div_ff = 3'h0;
  // line level; flip injects a short glitch
  assign o_rx_line = i_level ^ i_flip;
  // slave clock toggles every 5 cycles, stands low outside bursts
  always_ff @(posedge i_ref_clk) begin
    div_ff <= (div_ff == 3'h4 || !i_ext_run) ? 3'h0 : div_ff + 3'h1;
    if (!i_ext_run) o_ext_clk <= 1'b0;
    else if (div_ff == 3'h4) o_ext_clk <= ~o_ext_clk;
  end
endmodule : sbrg_line_model

// ==== verif/tb.sv ====
`timescale 1ns/1ps
// ***********************************************
// bench for the rate timer and line sampler
// ***********************************************
module tb;
  import sbrg_pkg::*;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, cen = 1;
  logic        level = 1, flip = 0, run = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]  htrans = 0;
  logic        hrdy, hresp, tick, stick, lvl, pen, rxl, ext;
  int          failures = 0, comparisons = 0, n, k;
  // sync, wide, high speed, prescale
  int mode [6][4] = '{'{0,0,0,64}, '{0,1,0,16}, '{0,0,1,16},
                      '{0,1,1,4}, '{1,0,0,4}, '{1,1,0,4}};
  // 40 MHz clock
  always #12.5 clk = ~clk;
  sbrg_core dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(cen),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .i_rx_line(rxl), .i_ext_clk(ext),
    .o_bit_tick(tick), .o_sample_tick(stick), .o_rx_level(lvl),
    .o_port_en(pen));
  sbrg_line_model line_u (.i_ref_clk(clk), .i_level(level), .i_flip(flip),
    .i_ext_run(run), .o_rx_line(rxl), .o_ext_clk(ext));
  // ***********************************************
  // helpers
  // ***********************************************
  task close_out;
    $display("checks %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // bounded wait on hready; a hung bus ends the run
  task rdy;
    int i;
    i = 0;
    do begin @(posedge clk); i++; end while (hrdy !== 1'b1 && i < 50);
    if (i >= 50) begin failures++; close_out; end
  endtask : rdy
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= wr;
    rdy;
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    rdy;
    q = hrdata;
  endtask : bus
  // edges until the next bit tick, bounded
  task wt(output int c);
    c = 0;
    do begin @(posedge clk); c++; end while (tick !== 1'b1 && c < 20000);
    if (c >= 20000) begin failures++; close_out; end
  endtask : wt
  // ***********************************************
  // scenarios
  // ***********************************************
  task t_regs;
    bus(0, ADDR_TX_CTRL, 0);   chk(q, {24'h0, RST_TX_CTRL});
    bus(0, ADDR_RX_CTRL, 0);   chk(q, {24'h0, RST_RX_CTRL});
    bus(0, ADDR_RATE_CTRL, 0); chk(q, {24'h0, RST_RATE_CTRL});
    bus(0, ADDR_DIV_LOW, 0);   chk(q, {24'h0, RST_DIV});
    bus(1, 8'h18, 32'hFF);
    bus(0, 8'h18, 0);          chk(q, 32'h0);
    bus(1, ADDR_DIV_HIGH, 32'hA5);
    bus(0, ADDR_DIV_HIGH, 0);  chk(q, 32'hA5);
    chk(pen, 1'b0);
    chk(hresp, 1'b0);
    $display("done registers");
  endtask : t_regs
  // every mode; high byte 1 must be ignored when narrow
  task t_rates;
    bus(1, ADDR_RX_CTRL, 32'h80);
    bus(1, ADDR_DIV_HIGH, 32'h01);
    chk(pen, 1'b1);
    for (k = 0; k < 6; k++) begin
      bus(1, ADDR_RATE_CTRL, 32'(mode[k][1] << POS_WIDE_DIV));
      bus(1, ADDR_TX_CTRL, 32'(8'h80 | mode[k][0] << POS_SYNC
                                      | mode[k][2] << POS_HIGH_SPD));
      bus(1, ADDR_DIV_LOW, 32'h02);
      wt(n); wt(n);
      chk(32'(n), 32'(mode[k][3] * (mode[k][1] ? 259 : 3)));
      chk(stick, 1'b1);
    end
    $display("done rates");
  endtask : t_rates
  // divisor rewrite mid-period restarts the count
  task t_restart;
    bus(1, ADDR_RATE_CTRL, 0);
    bus(1, ADDR_TX_CTRL, 32'h80);
    bus(1, ADDR_DIV_LOW, 32'h02);
    wt(n); repeat (100) @(posedge clk);
    bus(1, ADDR_DIV_LOW, 32'h02);
    wt(n); chk(n, int'(PRE_64) * 3 + 1);
    // a low enable freezes the timer, so the period stretches by it
    cen <= 0; repeat (50) @(posedge clk);
    cen <= 1;
    wt(n); chk(n, int'(PRE_64) * 3);
    $display("done restart");
  endtask : t_restart
  task t_vote;
    logic seen_low;
    seen_low = 0;
    @(posedge clk) flip <= 1;
    @(posedge clk) flip <= 0;
    repeat (10) @(posedge clk) if (lvl === 1'b0) seen_low = 1;
    chk(seen_low, 1'b0);
    level <= 0; repeat (8) @(posedge clk);
    chk(lvl, 1'b0);
    bus(0, ADDR_STATUS, 0); chk(q[0], 1'b0);
    level <= 1;
    $display("done vote");
  endtask : t_vote
  // slave: ticks follow the external clock only
  task t_slave;
    bus(1, ADDR_TX_CTRL, 32'h10);
    n = 0; repeat (60) @(posedge clk) if (tick === 1'b1) n++;
    chk(32'(n), 32'h0);
    run <= 1;
    n = 0; repeat (100) @(posedge clk) if (tick === 1'b1) n++;
    chk(n >= 9 && n <= 11, 1'b1);
    run <= 0;
    $display("done slave");
  endtask : t_slave
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    t_regs; t_rates; t_restart; t_vote; t_slave;
    close_out;
  end
endmodule : tb
